/* File: hw/blpl_top.sv */
/*
  Digital average power loop and burst gating of a burst-mode laser transmitter,
  with an AXI4-Lite register slave.
  Assumes synchronous inputs, a digitised monitor photocurrent and a host that
  respects the burst on and off minimums.
*/
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module blpl_top
  import blpl_pkg::*;
#(
  parameter int BIAS_W = 8,
  parameter int MON_W = 12
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic burstGatePos,
  input wire logic burstGateNeg,
  input wire logic txData,
  input wire logic [MON_W-1:0] monitorPhotoInput,
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [BIAS_W-1:0] biasCode,
  output logic biasOn,
  output logic [BIAS_W-1:0] modCode,
  output logic modOn,
  output logic modSink,
  output logic failN
);
  if (BIAS_W < 2 || BIAS_W > 8 || MON_W < 2 || MON_W > 16) begin : g_chk
    $error("blpl_top: BIAS_W must be 2..8 and MON_W 2..16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register slave
  logic awGot;
  logic wGot;
  logic [AXI_AW-1:0] wAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wrEn;
  logic [2:0] ctrl;
  logic [MON_W-1:0] powerTargetSet;
  logic [BIAS_W-1:0] biasCeilingSet;
  logic [BIAS_W-1:0] modLevelSet;
  logic [31:0] rdMux;
  logic rdOk;
  logic wrOk;
  blpl_state_t state;
  blpl_state_t next_state;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  assign wrEn = awGot && wGot && !bvalid;

  always_ff @(posedge clk) begin
    if (srst) begin
      awready <= 1'b1;
      awGot <= 1'b0;
      wAddr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      awGot <= 1'b1;
      wAddr <= awaddr;
    end else if (wrEn) begin
      awGot <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wready <= 1'b1;
      wGot <= 1'b0;
      wData <= '0;
      wStrb <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wGot <= 1'b1;
      wData <= wdata;
      wStrb <= wstrb;
    end else if (wrEn) begin
      wGot <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // Read-only words accept a write silently; only holes answer SLVERR
  assign wrOk = (wAddr[AXI_AW-1:2] <= ADDR_MONITOR[AXI_AW-1:2]);

  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wrEn) begin
      bvalid <= 1'b1;
      bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= CTRL_RST[2:0];
      powerTargetSet <= TARGET_RST[MON_W-1:0];
      biasCeilingSet <= CEIL_RST[BIAS_W-1:0];
      modLevelSet <= MOD_RST[BIAS_W-1:0];
    end else if (wrEn) begin
      case (wAddr[AXI_AW-1:2])
        ADDR_CTRL[AXI_AW-1:2]: ctrl <= 3'(merge({29'h0, ctrl}, wData, wStrb));
        ADDR_POWER_TARGET[AXI_AW-1:2]: powerTargetSet <= MON_W'(merge(32'(powerTargetSet), wData, wStrb));
        ADDR_BIAS_CEILING[AXI_AW-1:2]: biasCeilingSet <= BIAS_W'(merge(32'(biasCeilingSet), wData, wStrb));
        ADDR_MOD_LEVEL[AXI_AW-1:2]: modLevelSet <= BIAS_W'(merge(32'(modLevelSet), wData, wStrb));
        default: ;
      endcase
    end
  end

  always_comb begin
    rdMux = '0;
    rdOk = 1'b1;
    case (araddr[AXI_AW-1:2])
      ADDR_CTRL[AXI_AW-1:2]: rdMux[2:0] = ctrl;
      ADDR_POWER_TARGET[AXI_AW-1:2]: rdMux[MON_W-1:0] = powerTargetSet;
      ADDR_BIAS_CEILING[AXI_AW-1:2]: rdMux[BIAS_W-1:0] = biasCeilingSet;
      ADDR_MOD_LEVEL[AXI_AW-1:2]: rdMux[BIAS_W-1:0] = modLevelSet;
      ADDR_STATUS[AXI_AW-1:2]: begin
        rdMux[STS_FAIL_BIT] = failN;
        rdMux[STS_DONE_BIT] = (state == ST_FINE);
        rdMux[STS_BIAS_LSB +: BIAS_W] = biasCode;
        rdMux[STS_STATE_LSB +: 5] = state;
      end
      ADDR_MONITOR[AXI_AW-1:2]: rdMux[MON_W-1:0] = monitorPhotoInput;
      default: rdOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdMux;
      rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop sequencing
  logic chipDis;
  logic openLoop;
  logic gateOn;
  logic gatePrev;
  logic gateFall;
  logic [1:0] startKind;
  logic [1:0] burstCnt;
  logic [7:0] initLen;
  logic [7:0] initLenQ;
  logic [7:0] initAge;
  logic slowLast;
  logic initLast;
  logic enterInit;
  logic loopRun;
  logic tick;
  logic [3:0] updCnt;
  logic [BIAS_W-1:0] step;
  logic below;
  logic above;
  logic shorted;
  blpl_step_if #(.W(BIAS_W)) sif();

  assign chipDis = ctrl[CTRL_DIS_BIT];
  assign openLoop = ctrl[CTRL_OPEN_BIT];
  assign gateOn = burstGatePos && !burstGateNeg;
  assign gateFall = gatePrev && !gateOn;
  assign enterInit = (state == ST_WAIT) && (next_state == ST_SLOW);
  assign loopRun = (state == ST_SEARCH) || (state == ST_FINE);
  // A zero setting stands for a grounded set input
  assign shorted = (biasCeilingSet == '0) || (modLevelSet == '0);
  assign below = monitorPhotoInput < powerTargetSet;
  assign above = monitorPhotoInput > powerTargetSet;

  always_comb begin
    unique case (startKind)
      KIND_PWR: initLen = 8'(INIT_PWR_CYC);
      KIND_ENA: initLen = ctrl[CTRL_EXT_BIT] ? 8'(INIT_ENA_EXT_CYC) : 8'(INIT_ENA_CYC);
      default: initLen = 8'(INIT_BURST_CYC);
    endcase
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_OFF: if (!chipDis) next_state = ST_WAIT;
      ST_WAIT: if (gateOn) next_state = ST_SLOW;
      ST_SLOW: if (slowLast) next_state = ST_SEARCH;
      ST_SEARCH: begin
        // Whichever comes first: timeout or third burst
        if (initLast || burstCnt == 2'(INIT_BURSTS) || (gateFall && burstCnt == 2'(INIT_BURSTS - 1))) begin
          next_state = ST_FINE;
        end
      end
      ST_FINE: ;
    endcase
    if (chipDis) begin
      next_state = ST_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // Reset and enable release only count while the gate is seen at once
  always_ff @(posedge clk) begin
    if (srst) begin
      startKind <= KIND_PWR;
    end else if (state == ST_OFF) begin
      startKind <= KIND_ENA;
    end else if (state == ST_WAIT) begin
      startKind <= KIND_BURST;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      gatePrev <= 1'b0;
      burstCnt <= '0;
      initLenQ <= '0;
    end else begin
      gatePrev <= gateOn;
      if (enterInit) begin
        burstCnt <= '0;
        initLenQ <= initLen;
      end else if (gateFall && burstCnt != 2'(INIT_BURSTS) && (state == ST_SLOW || state == ST_SEARCH)) begin
        burstCnt <= burstCnt + 2'h1;
      end
    end
  end

  blpl_timer #(.W(8)) u_slow (
    .clk(clk),
    .srst(srst),
    .load(enterInit),
    .count(8'(SLOW_CYC)),
    .lastCycle(slowLast)
  );

  blpl_timer #(.W(8)) u_init (
    .clk(clk),
    .srst(srst),
    .load(enterInit),
    .count(initLen),
    .lastCycle(initLast)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bias regulation
  // Update pacing relies on bursts of the minimum length
  always_ff @(posedge clk) begin
    if (srst || !loopRun) begin
      updCnt <= '0;
    end else if (gateOn) begin
      updCnt <= (updCnt == 4'(UPD_CYC - 1)) ? 4'h0 : updCnt + 4'h1;
    end
  end

  assign tick = gateOn && loopRun && (updCnt == 4'(UPD_CYC - 1));

  // Halving steps give the coarse search; steps of one give the trim
  always_ff @(posedge clk) begin
    if (srst || state == ST_SLOW) begin
      step <= BIAS_W'(1) << (BIAS_W - 1);
    end else if (tick && state == ST_SEARCH && step > BIAS_W'(1)) begin
      step <= step >> 1;
    end
  end

  assign sif.bias = biasCode;
  assign sif.step = (state == ST_FINE) ? BIAS_W'(1) : step;
  assign sif.ceil = biasCeilingSet;
  assign sif.up = below;

  blpl_step u_step (
    .sif(sif)
  );

  always_ff @(posedge clk) begin
    if (srst || state == ST_OFF || state == ST_WAIT || state == ST_SLOW) begin
      biasCode <= '0;
    end else if (openLoop) begin
      biasCode <= biasCeilingSet;
    end else if (tick && (below || above)) begin
      biasCode <= sif.nextBias;
    end else if (biasCode > biasCeilingSet) begin
      biasCode <= biasCeilingSet;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state != ST_FINE) begin
      failN <= 1'b0;
    end else if (openLoop) begin
      failN <= 1'b1;
    end else begin
      // Cleared again as soon as neither limit blocks the loop
      failN <= !((sif.atTop && below) || (sif.atBottom && above));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output gating, one registered stage behind the gate
  always_ff @(posedge clk) begin
    if (srst) begin
      biasOn <= 1'b0;
      modOn <= 1'b0;
      modSink <= 1'b0;
      modCode <= '0;
    end else begin
      biasOn <= gateOn && loopRun && !shorted && !chipDis;
      modOn <= gateOn && loopRun && !shorted && !chipDis;
      modSink <= gateOn && txData && loopRun && !shorted && !chipDis;
      modCode <= modLevelSet;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !(state == ST_SLOW || state == ST_SEARCH)) begin
      initAge <= '0;
    end else if (initAge != 8'hFF) begin
      initAge <= initAge + 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_disable_off;
    @(posedge clk) disable iff (srst) chipDis |=> !biasOn && !modOn && state == ST_OFF;
  endproperty
  a_disable_off: assert property (p_disable_off) else $error("outputs on while disabled");

  property p_short_off;
    @(posedge clk) disable iff (srst) shorted |=> !biasOn && !modOn && !modSink;
  endproperty
  a_short_off: assert property (p_short_off) else $error("outputs on with grounded setting");

  property p_ceiling;
    @(posedge clk) disable iff (srst) $stable(biasCeilingSet) |-> biasCode <= biasCeilingSet;
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("bias above ceiling");

  property p_freeze;
    @(posedge clk) disable iff (srst) (state == ST_FINE && !gateOn && !wrEn && !openLoop) |=> $stable(biasCode);
  endproperty
  a_freeze: assert property (p_freeze) else $error("bias moved with gate low");

  property p_slow;
    @(posedge clk) disable iff (srst || chipDis) $rose(state == ST_SLOW) |-> (state == ST_SLOW)[*5] ##1 (state == ST_SEARCH);
  endproperty
  a_slow: assert property (p_slow) else $error("slow start length wrong");

  property p_init_len;
    @(posedge clk) disable iff (srst) (state == ST_SLOW || state == ST_SEARCH) |-> initAge < initLenQ;
  endproperty
  a_init_len: assert property (p_init_len) else $error("init overran its time");

  property p_fail_init;
    @(posedge clk) disable iff (srst) (state != ST_FINE) |=> !failN;
  endproperty
  a_fail_init: assert property (p_fail_init) else $error("fail high during init");

  property p_fail_low;
    @(posedge clk) disable iff (srst) (state == ST_FINE && !openLoop && biasCode == '0 && above) |=> !failN;
  endproperty
  a_fail_low: assert property (p_fail_low) else $error("no fail at bias floor");

  property p_mod_sink;
    @(posedge clk) disable iff (srst) modSink |-> $past(gateOn) && $past(txData) && biasOn;
  endproperty
  a_mod_sink: assert property (p_mod_sink) else $error("modulation without gate and data");

  property p_gate_on;
    @(posedge clk) disable iff (srst) (state == ST_FINE && gateOn && !shorted && !chipDis) |=> biasOn && modOn;
  endproperty
  a_gate_on: assert property (p_gate_on) else $error("outputs late after gate");

  property p_search_first;
    @(posedge clk) disable iff (srst) $rose(state == ST_FINE) |-> $past(state == ST_SEARCH);
  endproperty
  a_search_first: assert property (p_search_first) else $error("fine mode without search");

  c_fine: cover property (@(posedge clk) disable iff (srst) $rose(state == ST_FINE));
  c_burst_end: cover property (@(posedge clk) disable iff (srst) state == ST_SEARCH && gateFall && burstCnt == 2'h2);
  c_fail: cover property (@(posedge clk) disable iff (srst) state == ST_FINE ##1 !failN);
  c_reenable: cover property (@(posedge clk) disable iff (srst) state == ST_OFF ##1 state == ST_WAIT);
endmodule

/* File: pkg/blpl_pkg.sv */
/*
  Constants for the burst laser power loop: timing, register map, fields, states.
  Assumes a 10 MHz clock; all cycle counts but UPD_CYC derive from the printed times.
*/
package blpl_pkg;
  localparam int CLK_MHZ = 10;
  localparam int SLOW_NS = 450;
  localparam int INIT_ENA_NS = 2100;
  localparam int INIT_ENA_EXT_NS = 3720;
  localparam int INIT_PWR_NS = 12000;
  localparam int INIT_BURST_NS = 1600;
  localparam int GATE_ON_PS = 2300;
  localparam int GATE_OFF_PS = 2000;
  localparam int SLOW_CYC = (SLOW_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_ENA_CYC = (INIT_ENA_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_ENA_EXT_CYC = (INIT_ENA_EXT_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_PWR_CYC = (INIT_PWR_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_BURST_CYC = (INIT_BURST_NS * CLK_MHZ + 999) / 1000;
  // Sub-cycle limits floor to zero; one registered stage is the floor
  localparam int GATE_ON_CYC = (GATE_ON_PS * CLK_MHZ / 1000000) < 1 ? 1 : GATE_ON_PS * CLK_MHZ / 1000000;
  localparam int GATE_OFF_CYC = (GATE_OFF_PS * CLK_MHZ / 1000000) < 1 ? 1 : GATE_OFF_PS * CLK_MHZ / 1000000;
  localparam int INIT_BURSTS = 3;
  localparam int UPD_CYC = 4;
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_POWER_TARGET = 8'h04;
  localparam logic [7:0] ADDR_BIAS_CEILING = 8'h08;
  localparam logic [7:0] ADDR_MOD_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MONITOR = 8'h14;
  localparam int CTRL_DIS_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int CTRL_OPEN_BIT = 2;
  localparam int STS_FAIL_BIT = 0;
  localparam int STS_DONE_BIT = 1;
  localparam int STS_BIAS_LSB = 8;
  localparam int STS_STATE_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] TARGET_RST = 32'h00000800;
  localparam logic [31:0] CEIL_RST = 32'h000000FF;
  localparam logic [31:0] MOD_RST = 32'h00000080;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] KIND_PWR = 2'h0;
  localparam logic [1:0] KIND_ENA = 2'h1;
  localparam logic [1:0] KIND_BURST = 2'h2;
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_SLOW = 5'b00100,
    ST_SEARCH = 5'b01000,
    ST_FINE = 5'b10000
  } blpl_state_t;
endpackage

/* File: pkg/blpl_step_if.sv */
/*
  Carrier between the loop core and its bias step calculator.
  Assumes both ends share one clock; the calculator is purely combinational.
*/
`timescale 1ns/1ns
interface blpl_step_if #(
  parameter int W = 8
);
  logic [W-1:0] bias;
  logic [W-1:0] step;
  logic [W-1:0] ceil;
  logic up;
  logic [W-1:0] nextBias;
  logic atTop;
  logic atBottom;
  modport core(output bias, output step, output ceil, output up, input nextBias, input atTop, input atBottom);
  modport calc(input bias, input step, input ceil, input up, output nextBias, output atTop, output atBottom);
endinterface

/* File: hw/blpl_timer.sv */
/*
  Reloadable down counter; flags the last cycle of a loaded span.
  Assumes a load value of at least one.
*/
`timescale 1ns/1ns
module blpl_timer #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic lastCycle
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= count;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign lastCycle = (cnt == W'(1));
endmodule

/* File: hw/blpl_step.sv */
/*
  Bias step calculator: moves the bias by one step toward target, clamped to the ceiling.
  Assumes the core gates when the result is used.
*/
`timescale 1ns/1ns
module blpl_step (
  blpl_step_if.calc sif
);
  always_comb begin
    if (sif.bias >= sif.ceil) begin
      sif.nextBias = sif.up ? sif.ceil : ((sif.ceil > sif.step) ? sif.ceil - sif.step : '0);
    end else if (sif.up) begin
      sif.nextBias = ((sif.ceil - sif.bias) > sif.step) ? sif.bias + sif.step : sif.ceil;
    end else begin
      sif.nextBias = (sif.bias > sif.step) ? sif.bias - sif.step : '0;
    end
    sif.atTop = (sif.bias >= sif.ceil);
    sif.atBottom = (sif.bias == '0);
  end
endmodule

/* File: testbench/blpl_laser_model.sv */
/*
  Laser diode with back-facet monitor: turns the bias code into a photocurrent code.
  Assumes light only above a threshold code, linear above it, one clock of lag.
*/
`timescale 1ns/1ns
module blpl_laser_model #(
  parameter int THRESH = 20,
  parameter int SLOPE = 16
) (
  input wire logic clk,
  input wire logic [7:0] biasCode,
  input wire logic biasOn,
  input wire logic shorted,
  output logic [11:0] photo
);
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (shorted) begin
      photo <= 12'hFFF; // Cathode to ground lights fully whatever the bias
    end else if (!biasOn || int'(biasCode) <= THRESH) begin
      photo <= 12'h000;
    end else begin
      photo <= 12'((int'(biasCode) - THRESH) * SLOPE);
    end
  end
endmodule

/* File: testbench/burst_laser_power_loop_tb_top.sv */
/*
  Self-checking bench for the burst laser power loop, with a laser model on the far side.
  Assumes the AXI4-Lite map and cycle counts of the package and of the loop core.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin badCount++; $display("Error at %0t: got %0h exp %0h", $time, (a), (e)); end end
module burst_laser_power_loop_tb_top
  import blpl_pkg::*;
;
  localparam int THR = 20;
  localparam int SLP = 16;
  logic clk, srst, burstGatePos, burstGateNeg, txData, shorted;
  logic [11:0] monitorPhotoInput;
  logic [7:0] awaddr, araddr, biasCode, modCode;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic biasOn, modOn, modSink, failN;
  int badCount = 0;
  int checks = 0;
  logic [7:0] ra [4] = '{ADDR_CTRL, ADDR_POWER_TARGET, ADDR_BIAS_CEILING, ADDR_MOD_LEVEL};
  logic [31:0] rv [4] = '{CTRL_RST, TARGET_RST, CEIL_RST, MOD_RST};
  localparam logic [7:0] LOCK = 8'(TARGET_RST / SLP + THR);

  blpl_top dut (.clk(clk), .srst(srst), .burstGatePos(burstGatePos), .burstGateNeg(burstGateNeg),
    .txData(txData), .monitorPhotoInput(monitorPhotoInput), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .biasCode(biasCode), .biasOn(biasOn), .modCode(modCode),
    .modOn(modOn), .modSink(modSink), .failN(failN));
  blpl_laser_model #(.THRESH(THR), .SLOPE(SLP)) laser (.clk(clk), .biasCode(biasCode), .biasOn(biasOn),
    .shorted(shorted), .photo(monitorPhotoInput));

  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic gate(input logic on);
    burstGatePos <= on;
    burstGateNeg <= !on;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    `CHK(rresp, er)
  endtask
  // Flag must stay low at least lo cycles and rise before hi
  task automatic waitFail(input int lo, input int hi);
    int n;
    n = 0;
    while (failN !== 1'b1 && n < hi) begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= lo && n < hi, 1'b1)
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic tPowerUp;
    repeat (5) begin
      @(posedge clk);
      `CHK(biasOn, 1'b0)
    end
    waitFail(105, 130);
    cyc(150);
    `CHK(biasCode, LOCK)
    $display("test powerup done");
  endtask
  task automatic tRegs;
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(ra[i], d, RESP_OKAY);
      `CHK(d, rv[i])
    end
    rd(8'h18, d, RESP_SLVERR);
    `CHK(d, 32'h00000000)
    rd(ADDR_MONITOR, d, RESP_OKAY);
    `CHK(d, TARGET_RST)
    `CHK(modCode, MOD_RST[7:0])
    wstrb <= 4'hE; // Lane 0 masked: the narrow register must keep its value
    wr(ADDR_MOD_LEVEL, 32'h000000FF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(ADDR_MOD_LEVEL, d, RESP_OKAY);
    `CHK(d, MOD_RST)
    wr(8'h40, 32'h00000001, RESP_SLVERR);
    rd(ADDR_STATUS, d, RESP_OKAY);
    `CHK(d[20:16], 5'h10)
    `CHK(d[0], 1'b1)
    $display("test registers done");
  endtask
  task automatic tFreeze;
    logic [7:0] b;
    gate(1'b0);
    cyc(2);
    `CHK(biasOn, 1'b0)
    `CHK(modOn, 1'b0)
    b = biasCode;
    cyc(200);
    `CHK(biasCode, b)
    gate(1'b1);
    cyc(2);
    `CHK(biasOn, 1'b1)
    txData <= 1'b1;
    cyc(2);
    `CHK(modSink, 1'b1)
    txData <= 1'b0;
    cyc(2);
    `CHK(modSink, 1'b0)
    txData <= 1'b1;
    gate(1'b0);
    cyc(2);
    `CHK(modSink, 1'b0)
    gate(1'b1);
    $display("test freeze done");
  endtask
  task automatic tCeiling;
    wr(ADDR_BIAS_CEILING, 32'h00000064, RESP_OKAY);
    wr(ADDR_POWER_TARGET, 32'h00000FFF, RESP_OKAY);
    cyc(20);
    `CHK(biasCode, 8'h64)
    `CHK(failN, 1'b0)
    wr(ADDR_POWER_TARGET, TARGET_RST, RESP_OKAY);
    wr(ADDR_BIAS_CEILING, CEIL_RST, RESP_OKAY);
    cyc(250);
    `CHK(failN, 1'b1)
    `CHK(biasCode, LOCK)
    shorted <= 1'b1;
    cyc(650);
    `CHK(biasCode, 8'h00)
    `CHK(failN, 1'b0)
    shorted <= 1'b0;
    cyc(650);
    `CHK(failN, 1'b1)
    $display("test ceiling done");
  endtask
  task automatic tSettings;
    wr(ADDR_CTRL, 32'h00000004, RESP_OKAY);
    cyc(3);
    `CHK(biasCode, 8'hFF)
    wr(ADDR_CTRL, CTRL_RST, RESP_OKAY);
    for (int i = 2; i < 4; i++) begin
      wr(ra[i], 32'h00000000, RESP_OKAY);
      cyc(3);
      `CHK(biasOn, 1'b0)
      `CHK(modOn, 1'b0)
      wr(ra[i], rv[i], RESP_OKAY);
    end
    $display("test settings done");
  endtask
  task automatic tDisable;
    logic [31:0] d;
    wr(ADDR_CTRL, 32'h00000001, RESP_OKAY);
    cyc(2);
    `CHK(biasCode, 8'h00)
    `CHK(modOn, 1'b0)
    `CHK(failN, 1'b0)
    rd(ADDR_STATUS, d, RESP_OKAY);
    `CHK(d[20:16], 5'h01)
    wr(ADDR_CTRL, 32'h00000002, RESP_OKAY); // Long enable init selected
    waitFail(34, 60);
    wr(ADDR_CTRL, 32'h00000001, RESP_OKAY);
    wr(ADDR_CTRL, 32'h00000000, RESP_OKAY);
    waitFail(18, 34);
    gate(1'b0);
    wr(ADDR_CTRL, 32'h00000001, RESP_OKAY);
    wr(ADDR_CTRL, 32'h00000000, RESP_OKAY);
    cyc(10);
    gate(1'b1);
    waitFail(12, 25);
    $display("test disable done");
  endtask
  task automatic tThreeBursts;
    // Enable with the gate high: long init, so only the third burst can end it this early
    gate(1'b1);
    wr(ADDR_CTRL, 32'h00000003, RESP_OKAY);
    wr(ADDR_CTRL, 32'h00000002, RESP_OKAY);
    repeat (3) begin
      cyc(6); // Six cycles on, two off
      gate(1'b0);
      cyc(2);
      gate(1'b1);
    end
    waitFail(1, 4);
    $display("test three bursts done");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    burstGatePos = 1'b1; // Continuous mode
    burstGateNeg = 1'b0;
    txData = 1'b0;
    shorted = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    cyc(6);
    srst <= 1'b0;
    tPowerUp;
    tRegs;
    tFreeze;
    tCeiling;
    tSettings;
    tDisable;
    tThreeBursts;
    summarize;
  end
  initial begin
    cyc(6000);
    badCount++;
    $display("Error at %0t: watchdog expired", $time);
    summarize;
  end
endmodule
